// >>> serial_shift_pkg.sv
package serial_shift_pkg;

   localparam int SHIFT_W = 8;
   localparam int CNT_W = 4;
   localparam int RX_FIFO_DEPTH = 16;

   localparam logic [SHIFT_W-1:0] SHIFT_RESET = 8'h00;
   localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   localparam logic [CNT_W-1:0] CNT_MAX = 4'hf;
   localparam logic FLAG_RESET = 1'b0;
   localparam logic LATCH_RESET = 1'b0;
   localparam logic SCK_IDLE = 1'b0;

   localparam int SYNC_STAGES = 2;
   localparam int LINK_CLK_PERIOD_NS = 320;

   typedef struct packed {
      logic di;
      logic sck;
   } pin_in_t;

   typedef struct packed {
      logic do_o;
      logic sda_o;
      logic sda_oe_n;
      logic sck_o;
      logic sck_oe_n;
   } pin_out_t;

   typedef struct packed {
      logic ovf;
      logic start;
      logic overrun;
   } flags_t;

   localparam flags_t FLAGS_RESET = 3'h0;

   typedef enum logic [2:0] {
      LINK_IDLE = 3'b001,
      LINK_BUSY = 3'b010,
      LINK_STALL = 3'b100
   } link_state_t;

endpackage

// >>> pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
   parameter int W = 2
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);

   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } sync_state_t;

   sync_state_t st_r;
   sync_state_t st_nxt;

   // stage1 feeds stage2 only, so metastability never reaches logic
   always_comb begin
      st_nxt = st_r;
      st_nxt.stage1 = i_async;
      st_nxt.stage2 = st_r.stage1;
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_sync = st_r.stage2;

endmodule

// >>> stream_fifo.sv
`timescale 1ns/10ps
module stream_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [W-1:0] i_in_data,
   input wire logic i_in_valid,
   output logic o_in_ready,
   output logic [W-1:0] o_out_data,
   output logic o_out_valid,
   input wire logic i_out_ready
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } fifo_state_t;

   fifo_state_t st_r;
   fifo_state_t st_nxt;
   logic push;
   logic pop;

   assign o_in_ready = (st_r.cnt != (AW+1)'(DEPTH));
   assign o_out_valid = (st_r.cnt != '0);
   assign o_out_data = st_r.mem[st_r.rp];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wp] = i_in_data;
         st_nxt.wp = st_r.wp + 1'b1;
      end
      if (pop) begin
         st_nxt.rp = st_r.rp + 1'b1;
      end
      if (push && !pop) begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end else if (pop && !push) begin
         st_nxt.cnt = st_r.cnt - 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule

// >>> universal_serial_unit.sv
// Function
// - an 8-bit shift register holds incoming and outgoing bits and is read and written directly.
// - a 16-entry receive fifo keeps each byte completed without a cpu shift write; when full a master holds its clock,
// while a slave drops the byte, flags overrun, and further shifting overwrites the shift register itself.
// - the top bit of the shift register drives one of two output pins chosen by the wire mode.
// - a latch moves the output change to the clock edge opposite the input sampling edge.
// - serial input is always sampled from the serial data input pin in every configuration.
// - a 4-bit bit counter can be read and written directly.
// - a counter overflow can raise an interrupt request.
// - shift register and counter are clocked together from one clock source.
// - two-wire synchronous transfer works as master or as slave.
// - three-wire synchronous transfer works as master or as slave.
// - in two-wire mode a start condition is detected and can raise an interrupt.
// - the unit can wake the processor from idle, and in two-wire mode from every sleep mode.
`timescale 1ns/10ps
module universal_serial_unit (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_two_wire,
   input wire logic i_master,
   input wire logic i_tick,
   input wire logic i_shift_wr,
   input wire logic [7:0] i_shift_wdata,
   output logic [7:0] o_shift_rdata,
   input wire logic i_cnt_wr,
   input wire logic [3:0] i_cnt_wdata,
   output logic [3:0] o_cnt_rdata,
   input wire logic i_ovf_clr,
   input wire logic i_start_clr,
   input wire logic i_overrun_clr,
   output logic o_ovf_irq,
   output logic o_start_irq,
   output logic o_overrun,
   output logic o_wake_idle,
   output logic o_wake_deep,
   output logic [2:0] o_link_state,
   input wire serial_shift_pkg::pin_in_t i_pins,
   output serial_shift_pkg::pin_out_t o_pins,
   output logic [7:0] o_rx_data,
   output logic o_rx_valid,
   input wire logic i_rx_ready
);

   typedef struct packed {
      logic prev_sck;
      logic prev_di;
      logic [serial_shift_pkg::SHIFT_W-1:0] shift;
      logic [serial_shift_pkg::CNT_W-1:0] count;
      logic out_latch;
      logic sck_level;
      serial_shift_pkg::flags_t flags;
      serial_shift_pkg::link_state_t link;
   } core_state_t;

   function automatic logic rose(input logic prev, input logic cur);
      rose = !prev && cur;
   endfunction

   function automatic logic fell(input logic prev, input logic cur);
      fell = prev && !cur;
   endfunction

   core_state_t st_r;
   core_state_t st_nxt;
   serial_shift_pkg::pin_in_t pins_s;
   logic rise_evt;
   logic fall_evt;
   logic scl_now;
   logic start_evt;
   logic wrap_evt;
   logic push;
   logic fifo_ready;
   logic [7:0] shifted;

   pin_sync #(
      .W(2)
   ) u_sync (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_async(i_pins),
      .o_sync(pins_s)
   );

   // master makes its clock from i_tick and waits on a full fifo; a slave cannot be held off
   always_comb begin
      if (i_master) begin
         rise_evt = i_tick && !st_r.sck_level && fifo_ready;
         fall_evt = i_tick && st_r.sck_level;
         scl_now = st_r.sck_level;
      end else begin
         rise_evt = rose(st_r.prev_sck, pins_s.sck);
         fall_evt = fell(st_r.prev_sck, pins_s.sck);
         scl_now = pins_s.sck;
      end
   end

   // sda falling while scl is high and steady; the data pin doubles as sda
   assign start_evt = i_two_wire && scl_now && (i_master || st_r.prev_sck)
      && fell(st_r.prev_di, pins_s.di);
   assign shifted = {st_r.shift[6:0], pins_s.di};
   assign wrap_evt = rise_evt && !i_cnt_wr && (st_r.count == serial_shift_pkg::CNT_MAX);
   assign push = wrap_evt && !i_shift_wr;

   always_comb begin
      st_nxt = st_r;
      st_nxt.prev_sck = pins_s.sck;
      st_nxt.prev_di = pins_s.di;
      if (i_master) begin
         if (rise_evt || fall_evt) begin
            st_nxt.sck_level = !st_r.sck_level;
         end
      end else begin
         st_nxt.sck_level = serial_shift_pkg::SCK_IDLE;
      end
      // one shift clock moves data and counter together
      if (i_shift_wr) begin
         st_nxt.shift = i_shift_wdata;
      end else if (rise_evt) begin
         st_nxt.shift = shifted;
      end
      if (i_cnt_wr) begin
         st_nxt.count = i_cnt_wdata;
      end else if (rise_evt) begin
         st_nxt.count = st_r.count + serial_shift_pkg::CNT_ONE;
      end
      // a cpu write presents the new top bit at once so the first bit is ready
      if (i_shift_wr) begin
         st_nxt.out_latch = i_shift_wdata[7];
      end else if (fall_evt) begin
         st_nxt.out_latch = st_r.shift[7];
      end
      // the set term is evaluated last so a clear in the same cycle loses
      if (i_ovf_clr) begin
         st_nxt.flags.ovf = 1'b0;
      end
      if (wrap_evt) begin
         st_nxt.flags.ovf = 1'b1;
      end
      if (i_start_clr) begin
         st_nxt.flags.start = 1'b0;
      end
      if (start_evt) begin
         st_nxt.flags.start = 1'b1;
      end
      if (i_overrun_clr) begin
         st_nxt.flags.overrun = 1'b0;
      end
      if (push && !fifo_ready) begin
         st_nxt.flags.overrun = 1'b1;
      end
      case (st_r.link)
         serial_shift_pkg::LINK_IDLE: begin
            // a refused first tick holds the clock just as one in mid-byte does
            if (i_master && i_tick && !st_r.sck_level && !fifo_ready) begin
               st_nxt.link = serial_shift_pkg::LINK_STALL;
            end else if (rise_evt || fall_evt) begin
               st_nxt.link = serial_shift_pkg::LINK_BUSY;
            end
         end
         serial_shift_pkg::LINK_BUSY: begin
            if (i_master && i_tick && !fifo_ready) begin
               st_nxt.link = serial_shift_pkg::LINK_STALL;
            end else if (wrap_evt) begin
               st_nxt.link = serial_shift_pkg::LINK_IDLE;
            end
         end
         serial_shift_pkg::LINK_STALL: begin
            if (fifo_ready) begin
               st_nxt.link = serial_shift_pkg::LINK_BUSY;
            end
         end
         default: begin
            st_nxt.link = serial_shift_pkg::LINK_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r.prev_sck <= 1'b0;
         st_r.prev_di <= 1'b0;
         st_r.shift <= serial_shift_pkg::SHIFT_RESET;
         st_r.count <= serial_shift_pkg::CNT_RESET;
         st_r.out_latch <= serial_shift_pkg::LATCH_RESET;
         st_r.sck_level <= serial_shift_pkg::SCK_IDLE;
         st_r.flags <= serial_shift_pkg::FLAGS_RESET;
         st_r.link <= serial_shift_pkg::LINK_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // completed words are copied out; the shift register itself stays unbuffered
   stream_fifo #(
      .W(serial_shift_pkg::SHIFT_W),
      .DEPTH(serial_shift_pkg::RX_FIFO_DEPTH)
   ) u_rx_fifo (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_in_data(shifted),
      .i_in_valid(push),
      .o_in_ready(fifo_ready),
      .o_out_data(o_rx_data),
      .o_out_valid(o_rx_valid),
      .i_out_ready(i_rx_ready)
   );

   // two-wire pins are open drain: only a low is ever driven
   always_comb begin
      o_pins.sda_o = 1'b0;
      if (i_two_wire) begin
         o_pins.do_o = 1'b0;
         o_pins.sda_oe_n = st_r.out_latch;
         o_pins.sck_o = 1'b0;
         o_pins.sck_oe_n = !i_master || st_r.sck_level;
      end else begin
         o_pins.do_o = st_r.out_latch;
         o_pins.sda_oe_n = 1'b1;
         o_pins.sck_o = st_r.sck_level;
         o_pins.sck_oe_n = !i_master;
      end
   end

   assign o_shift_rdata = st_r.shift;
   assign o_cnt_rdata = st_r.count;
   assign o_ovf_irq = st_r.flags.ovf;
   assign o_start_irq = st_r.flags.start;
   assign o_overrun = st_r.flags.overrun;
   assign o_wake_idle = st_r.flags.ovf || st_r.flags.start;
   assign o_wake_deep = i_two_wire && st_r.flags.start;
   assign o_link_state = st_r.link;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   a_count_tracks_shift: assert property (
      rise_evt && !i_cnt_wr |=> o_cnt_rdata == 4'($past(o_cnt_rdata) + 4'h1))
      else $error("counter did not advance on shift clock");

   a_shift_takes_di: assert property (
      rise_evt && !i_shift_wr |=> o_shift_rdata[0] == $past(pins_s.di)
         && o_shift_rdata[7:1] == $past(o_shift_rdata[6:0]))
      else $error("shift did not take the data input pin");

   a_shift_write: assert property (
      i_shift_wr |=> o_shift_rdata == $past(i_shift_wdata) ##1
         (o_shift_rdata == $past(o_shift_rdata) || $past(rise_evt) || $past(i_shift_wr)))
      else $error("shift register write lost or changed without a clock");

   a_count_write: assert property (
      i_cnt_wr |=> o_cnt_rdata == $past(i_cnt_wdata))
      else $error("counter write lost");

   a_wrap_sets_ovf: assert property (
      rise_evt && !i_cnt_wr && o_cnt_rdata == 4'hf |=> o_cnt_rdata == 4'h0 && o_ovf_irq)
      else $error("wrap did not clear counter and set overflow");

   a_ovf_set_wins: assert property (
      wrap_evt && i_ovf_clr |=> o_ovf_irq ##1 (o_ovf_irq || $past(i_ovf_clr)))
      else $error("overflow lost against clear");

   a_latch_on_fall: assert property (
      fall_evt && !i_shift_wr |=> st_r.out_latch == $past(o_shift_rdata[7]))
      else $error("output latch missed the opposite edge");

   a_latch_steady: assert property (
      !fall_evt && !i_shift_wr |=> $stable(st_r.out_latch))
      else $error("output changed on the sampling edge");

   a_pin_by_mode: assert property (
      (i_two_wire |-> o_pins.sda_oe_n == st_r.out_latch && !o_pins.do_o)
      and (!i_two_wire |-> o_pins.do_o == st_r.out_latch && o_pins.sda_oe_n))
      else $error("top bit on wrong output pin");

   a_start_flagged: assert property (
      start_evt |=> o_start_irq [*1] ##1 (o_start_irq || $past(i_start_clr)))
      else $error("start condition not flagged");

   a_deep_wake: assert property (
      o_wake_deep |-> i_two_wire && o_wake_idle)
      else $error("deep wake outside two-wire start");

   a_master_stalls: assert property (
      i_master && i_tick && !fifo_ready && !st_r.sck_level |=> !st_r.sck_level)
      else $error("master clocked into a full fifo");

   a_overrun_flag: assert property (
      push && !fifo_ready |=> o_overrun)
      else $error("dropped word not flagged");

   a_count_holds: assert property (
      !rise_evt && !i_cnt_wr |=> $stable(o_cnt_rdata))
      else $error("counter moved without a shift clock");

   a_shift_holds: assert property (
      !rise_evt && !i_shift_wr |=> $stable(o_shift_rdata))
      else $error("shift register moved without a shift clock");

   a_ovf_sticky: assert property (
      o_ovf_irq && !i_ovf_clr |=> o_ovf_irq)
      else $error("overflow flag dropped without a clear");

   a_ovf_clears: assert property (
      i_ovf_clr && !wrap_evt |=> !o_ovf_irq)
      else $error("overflow clear ignored");

   a_ovf_only_wrap: assert property (
      !o_ovf_irq && !wrap_evt |=> !o_ovf_irq)
      else $error("overflow set without a wrap");

   a_start_sticky: assert property (
      o_start_irq && !i_start_clr |=> o_start_irq)
      else $error("start flag dropped without a clear");

   a_start_two_wire: assert property (
      !i_two_wire && !o_start_irq |=> !o_start_irq)
      else $error("start flagged outside two-wire mode");

   a_wake_on_flag: assert property (
      (o_ovf_irq || o_start_irq) |-> o_wake_idle)
      else $error("flag raised without an idle wake");

   a_open_drain: assert property (
      i_two_wire |-> !o_pins.sck_o && !o_pins.sda_o && !o_pins.do_o)
      else $error("two-wire pin driven high");

   a_three_wire_clk: assert property (
      !i_two_wire && i_master |-> !o_pins.sck_oe_n && o_pins.sck_o == st_r.sck_level)
      else $error("three-wire master clock not driven");

   a_slave_releases: assert property (
      !i_master |-> o_pins.sck_oe_n)
      else $error("slave drives the clock pin");

   a_overrun_sticky: assert property (
      o_overrun && !i_overrun_clr |=> o_overrun)
      else $error("overrun flag dropped without a clear");

   a_link_one_hot: assert property (
      $onehot(o_link_state))
      else $error("link state not one-hot");

   c_wrap_seen: cover property (wrap_evt);
   c_start_seen: cover property (start_evt ##1 o_wake_deep);
   c_master_byte: cover property (i_master && !i_two_wire && push);
   c_fifo_full: cover property (!fifo_ready ##1 o_rx_valid && i_rx_ready);
   c_stall_seen: cover property (o_link_state == 3'b100);

endmodule

// >>> serial_peer.sv
`timescale 1ns/10ps
module serial_peer (
   input wire logic i_sck,
   input wire logic i_do,
   output logic o_sck,
   output logic o_di,
   output logic [7:0] o_got
);
   logic [7:0] tx_r;
   initial begin
      o_sck = 1'b0;
      o_di = 1'b1;
      o_got = 8'h00;
      tx_r = 8'h00;
   end
   always @(posedge i_sck) o_got <= {o_got[6:0], i_do};
   // next bit after the falling edge, so it is stable around the rising one
   always @(negedge i_sck) begin
      tx_r = {tx_r[6:0], ~tx_r[7]};
      o_di = tx_r[7];
   end
   task automatic load(input logic [7:0] b);
      tx_r = b;
      o_di = b[7];
   endtask
   task automatic frame(input logic [7:0] b);
      load(b);
      #160;
      repeat (8) begin
         o_sck = 1'b1;
         #160;
         o_sck = 1'b0;
         #160;
      end
      // inverted line: do not leave the last bit standing
      o_di = ~o_di;
   endtask
   task automatic start_cond();
      o_di = 1'b1;
      o_sck = 1'b1;
      #320;
      o_di = 1'b0;
      #320;
      o_sck = 1'b0;
      #320;
      o_di = 1'b1;
   endtask
endmodule

// >>> tb.sv
`timescale 1ns/10ps
module tb;
   logic i_clk, i_resetn, i_two_wire, i_master, i_tick, i_shift_wr, i_cnt_wr;
   logic [7:0] i_shift_wdata, o_shift_rdata, o_rx_data, got;
   logic [3:0] i_cnt_wdata, o_cnt_rdata;
   logic i_ovf_clr, i_start_clr, i_overrun_clr, o_ovf_irq, o_start_irq, o_overrun;
   logic o_wake_idle, o_wake_deep, o_rx_valid, i_rx_ready, peer_sck, peer_di;
   logic [2:0] o_link_state;
   serial_shift_pkg::pin_in_t i_pins;
   serial_shift_pkg::pin_out_t o_pins;
   int error_cnt = 0;
   int comparisons = 0;
   logic [31:0] seed = 32'hb8310bea;
   logic [7:0] exp_q[$];
   logic [7:0] a, b;
   // open drain data: either side pulls low, pull-up otherwise
   assign i_pins.sck = i_master ? (o_pins.sck_o | o_pins.sck_oe_n) : peer_sck;
   assign i_pins.di = peer_di & (o_pins.sda_oe_n | o_pins.sda_o);
   universal_serial_unit dut_u (.i_clk, .i_resetn, .i_two_wire, .i_master, .i_tick,
      .i_shift_wr, .i_shift_wdata, .o_shift_rdata, .i_cnt_wr, .i_cnt_wdata, .o_cnt_rdata,
      .i_ovf_clr, .i_start_clr, .i_overrun_clr, .o_ovf_irq, .o_start_irq, .o_overrun,
      .o_wake_idle, .o_wake_deep, .o_link_state, .i_pins, .o_pins, .o_rx_data,
      .o_rx_valid, .i_rx_ready);
   serial_peer peer_u (.i_sck(i_pins.sck), .i_do(i_two_wire ? i_pins.di : o_pins.do_o),
      .o_sck(peer_sck), .o_di(peer_di), .o_got(got));
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   function automatic logic [7:0] rnd();
      seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
      return seed[7:0];
   endfunction
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] s, input logic [3:0] c);
      @(negedge i_clk);
      i_shift_wr = 1'b1;
      i_shift_wdata = s;
      i_cnt_wr = 1'b1;
      i_cnt_wdata = c;
      @(negedge i_clk);
      i_shift_wr = 1'b0;
      i_cnt_wr = 1'b0;
   endtask
   task automatic clr(input logic [2:0] c);
      {i_ovf_clr, i_start_clr, i_overrun_clr} = c;
      @(negedge i_clk);
      {i_ovf_clr, i_start_clr, i_overrun_clr} = 3'h0;
      @(negedge i_clk);
   endtask
   // four clocks a half period gives the same 320 ns link period
   task automatic tick(input logic c);
      i_tick = 1'b1;
      i_ovf_clr = c;
      @(negedge i_clk);
      i_tick = 1'b0;
      i_ovf_clr = 1'b0;
      repeat (3) @(negedge i_clk);
   endtask
   // two-wire data is wired-and, so both ends read back what both let through
   function automatic logic [7:0] line_byte(input logic tw, input logic [7:0] tx,
      input logic [7:0] rx);
      return tw ? (tx & rx) : rx;
   endfunction
   task automatic xfer(input logic [7:0] tx, input logic [7:0] rx);
      logic [7:0] e;
      e = line_byte(i_two_wire, tx, rx);
      wr(tx, 4'h8);
      chk(8'(i_two_wire ? o_pins.sda_oe_n : o_pins.do_o), 8'(tx[7]), "first bit");
      if (i_master) begin
         peer_u.load(rx);
         // the first bit must clear the pin synchroniser before the first shift edge
         repeat (3) @(negedge i_clk);
         // a clear at the wrapping tick must lose against the overflow set
         for (int t = 0; t < 16; t++)
            tick(t == 14);
      end else
         peer_u.frame(rx);
      repeat (5) @(negedge i_clk);
      chk(got, i_two_wire ? e : tx, "peer byte");
      chk(o_shift_rdata, e, "shift");
      chk(8'(o_cnt_rdata), 8'h00, "count");
      chk(8'(o_ovf_irq), 8'h01, "ovf");
      chk(8'(o_wake_idle), 8'h01, "wake");
      clr(3'h4);
      chk(8'(o_ovf_irq), 8'h00, "ovf clr");
      if (exp_q.size() < 16)
         exp_q.push_back(e);
   endtask
   initial begin
      #2000000;
      error_cnt++;
      $display("BAD %0t timeout", $time);
      print_verdict();
   end
   initial begin
      {i_resetn, i_two_wire, i_master, i_tick, i_shift_wr, i_cnt_wr} = 6'h0;
      {i_ovf_clr, i_start_clr, i_overrun_clr, i_rx_ready} = 4'h0;
      i_shift_wdata = 8'h00;
      i_cnt_wdata = 4'h0;
      repeat (20) @(negedge i_clk);
      i_resetn = 1'b1;
      @(negedge i_clk);
      chk(o_shift_rdata, 8'h00, "rst shift");
      chk({o_cnt_rdata, 1'b0, o_link_state}, 8'h01, "rst cnt/link");
      chk({5'h0, o_ovf_irq, o_start_irq, o_rx_valid}, 8'h00, "rst flags");
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         a = (i == 0) ? 8'hff : rnd();
         wr(a, a[3:0]);
         chk(o_shift_rdata, a, "shift wr");
         chk(8'(o_cnt_rdata), 8'(a[3:0]), "cnt wr");
      end
      $display("test registers done");
      for (int m = 0; m < 4; m++) begin
         {i_two_wire, i_master} = 2'(m);
         for (int k = 0; k < 3; k++) begin
            a = rnd();
            b = rnd();
            xfer(a, b);
         end
      end
      chk(8'(o_overrun), 8'h00, "no overrun");
      $display("test modes done");
      {i_two_wire, i_master} = 2'h0;
      // an all-ones byte keeps sda released so only the peer moves it
      wr(8'hff, 4'h0);
      peer_u.start_cond();
      repeat (5) @(negedge i_clk);
      chk(8'(o_start_irq), 8'h00, "start 3w");
      i_two_wire = 1'b1;
      peer_u.start_cond();
      repeat (5) @(negedge i_clk);
      chk({o_start_irq, o_wake_deep}, 8'h03, "start 2w");
      clr(3'h2);
      chk(8'(o_start_irq), 8'h00, "start clr");
      $display("test start done");
      i_two_wire = 1'b0;
      for (int k = 0; k < 5; k++)
         xfer(rnd(), rnd());
      chk(8'(o_overrun), 8'h01, "overrun");
      i_master = 1'b1;
      tick(1'b0);
      chk({o_cnt_rdata, 1'b0, o_link_state}, 8'h04, "stall");
      i_master = 1'b0;
      while (exp_q.size() > 0) begin
         for (int n = 0; o_rx_valid !== 1'b1; n++) begin
            if (n > 50) begin
               error_cnt++;
               $display("BAD %0t no word", $time);
               print_verdict();
            end
            @(negedge i_clk);
         end
         chk(o_rx_data, exp_q.pop_front(), "fifo");
         i_rx_ready = 1'b1;
         @(negedge i_clk);
         i_rx_ready = 1'b0;
         @(negedge i_clk);
      end
      chk(8'(o_rx_valid), 8'h00, "empty");
      clr(3'h1);
      chk(8'(o_overrun), 8'h00, "overrun clr");
      $display("test fifo done");
      print_verdict();
   end
endmodule
